// file: rtl/offset_trim_regs.sv
// Offset trim register bank for the converter cores, reached over AXI4-Lite.
//
// Behaviour
// R1 - A 12-bit unsigned offset in bits 11 to 0 is held and applied when the first core samples the second input.
// R2 - A separate 12-bit offset is held and applied when the second core samples the first input.
// R3 - A separate 12-bit offset is held and applied when the second core samples the second input.
// R4 - Each offset field is an unsigned binary number, never two's complement.
// R5 - After reset each field reads the factory trim value, and host writes replace it.
// R6 - The host must not write any offset register while a foreground calibration run is going.
// R7 - The host must not write any offset register while both background enables are set.
// R8 - With foreground offset calibration on and background offset off, the host reads only once foreground-complete reads 1.
// R9 - With both background enables on, the host reads only while the stopped flag reads 1.
// R10 - The host writes zeros to the four reserved upper bits of each offset register.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/100ps
`include "offset_trim_consts.svh"
module offset_trim_regs
  import offset_trim_pkg::*;
#(
  parameter trim_word_type FACTORY_TRIM_0 = `RESET_TRIM_FACTORY,
  parameter trim_word_type FACTORY_TRIM_1 = `RESET_TRIM_FACTORY,
  parameter trim_word_type FACTORY_TRIM_2 = `RESET_TRIM_FACTORY
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // AXI4-Lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Calibration engine status
  input wire logic foreground_calibration_running,
  input wire logic foreground_calibration_complete,
  input wire logic calibration_stopped_flag,
  // Calibration enables
  output logic background_calibration_enable,
  output logic background_offset_calibration_enable,
  output logic foreground_offset_calibration_enable,
  // Offsets applied to the core and input pairings
  output logic [11:0] offset_trim_core0_input_b,
  output logic [11:0] offset_trim_core1_input_a,
  output logic [11:0] offset_trim_core1_input_b
);

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------

  function automatic reg_sel_type decode_sel(input logic [11:0] addr);
    logic [9:0] idx;
    idx = addr[11:2];
    if (addr[1:0] != 2'h0) begin
      decode_sel = sel_none;
    end else if (idx == `IDX_TRIM_CORE0_INPUT_B || idx == `IDX_TRIM_CORE1_INPUT_A
                 || idx == `IDX_TRIM_CORE1_INPUT_B) begin
      decode_sel = sel_trim;
    end else if (idx == `IDX_CAL_CONTROL) begin
      decode_sel = sel_ctrl;
    end else if (idx == `IDX_CAL_STATUS) begin
      decode_sel = sel_stat;
    end else begin
      decode_sel = sel_none;
    end
  endfunction

  function automatic logic [1:0] trim_slot(input logic [11:0] addr);
    logic [9:0] idx;
    idx = addr[11:2];
    if (idx == `IDX_TRIM_CORE0_INPUT_B) begin
      trim_slot = 2'd0;
    end else if (idx == `IDX_TRIM_CORE1_INPUT_A) begin
      trim_slot = 2'd1;
    end else begin
      trim_slot = 2'd2;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Trim word store
  // --------------------------------------------------------------------------

  trim_store_if store_bus ();

  trim_store #(
    .FACTORY_TRIM_0(FACTORY_TRIM_0),
    .FACTORY_TRIM_1(FACTORY_TRIM_1),
    .FACTORY_TRIM_2(FACTORY_TRIM_2)
  ) u_store (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .port(store_bus.store)
  );

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------

  bus_state_type state;
  bus_state_type next_state;
  reg_sel_type wsel;
  reg_sel_type rsel;

  always_comb begin
    next_state = state;
    wsel = decode_sel(state.awaddr);
    rsel = decode_sel(state.araddr);
    store_bus.we = 1'b0;
    store_bus.waddr = trim_slot(state.awaddr);
    store_bus.wdata = state.wdata[15:0];
    store_bus.wstrb = state.wstrb[1:0];
    store_bus.re = 1'b0;
    store_bus.raddr = trim_slot(s_axi_araddr);

    // Address and data are latched independently, in either order.
    if (state.aw_ready && s_axi_awvalid) begin
      next_state.aw_ready = 1'b0;
      next_state.awaddr = s_axi_awaddr;
    end
    if (state.w_ready && s_axi_wvalid) begin
      next_state.w_ready = 1'b0;
      next_state.wdata = s_axi_wdata;
      next_state.wstrb = s_axi_wstrb;
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end

    // The write waits for both halves and for the previous response to drain.
    if (!state.aw_ready && !state.w_ready && !state.bvalid) begin
      next_state.bvalid = 1'b1;
      next_state.aw_ready = 1'b1;
      next_state.w_ready = 1'b1;
      next_state.bresp = `RESP_OKAY;
      if (wsel == sel_trim) begin
        store_bus.we = 1'b1; // R5
      end else if (wsel == sel_ctrl) begin
        if (state.wstrb[0]) begin
          next_state.cal_ctrl = state.wdata[2:0];
        end
      end else if (wsel == sel_none) begin
        next_state.bresp = `RESP_SLVERR;
      end
    end

    // Read: the store answers on the same edge that takes the address.
    if (state.ar_ready && s_axi_arvalid) begin
      next_state.ar_ready = 1'b0;
      next_state.rd_pend = 1'b1;
      next_state.araddr = s_axi_araddr;
      store_bus.re = 1'b1;
    end
    if (state.rd_pend) begin
      next_state.rd_pend = 1'b0;
      next_state.rvalid = 1'b1;
      next_state.rresp = `RESP_OKAY;
      next_state.rdata = 32'h0000_0000;
      if (rsel == sel_trim) begin
        next_state.rdata[15:0] = store_bus.rdata; // R4
      end else if (rsel == sel_ctrl) begin
        next_state.rdata[2:0] = state.cal_ctrl;
      end else if (rsel == sel_stat) begin
        next_state.rdata[`STAT_FOREGROUND_CALIBRATION_COMPLETE_BIT] = foreground_calibration_complete;
        next_state.rdata[`STAT_STOPPED_BIT] = calibration_stopped_flag;
        next_state.rdata[`STAT_FG_RUNNING_BIT] = foreground_calibration_running;
      end else begin
        next_state.rresp = `RESP_SLVERR;
      end
    end
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
      next_state.ar_ready = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
      state.aw_ready <= 1'b1;
      state.w_ready <= 1'b1;
      state.ar_ready <= 1'b1;
      state.cal_ctrl <= `RESET_CAL_CONTROL;
    end else begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------

  assign s_axi_awready = state.aw_ready;
  assign s_axi_wready = state.w_ready;
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp = state.bresp;
  assign s_axi_arready = state.ar_ready;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;
  assign background_calibration_enable = state.cal_ctrl[`CTRL_BG_CAL_BIT];
  assign background_offset_calibration_enable = state.cal_ctrl[`CTRL_BG_OFS_BIT];
  assign foreground_offset_calibration_enable = state.cal_ctrl[`CTRL_FG_OFS_BIT];

  // Only the low 12 bits steer the cores; the reserved nibble is stored but unused.
  assign offset_trim_core0_input_b = store_bus.words[0][`TRIM_VALUE_MSB:0]; // R1
  assign offset_trim_core1_input_a = store_bus.words[1][`TRIM_VALUE_MSB:0]; // R2
  assign offset_trim_core1_input_b = store_bus.words[2][`TRIM_VALUE_MSB:0]; // R3

endmodule // offset_trim_regs

// file: rtl/offset_trim_consts.svh
// Register indices, field positions, reset values and bus codes of the offset trim bank.
`ifndef OFFSET_TRIM_CONSTS_SVH
`define OFFSET_TRIM_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_TRIM_CORE0_INPUT_B 10'h08c
`define IDX_TRIM_CORE1_INPUT_A 10'h08e
`define IDX_TRIM_CORE1_INPUT_B 10'h090
`define IDX_CAL_CONTROL 10'h0a0
`define IDX_CAL_STATUS 10'h0a1

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define TRIM_VALUE_MSB 11
`define TRIM_RSVD_MSB 15
`define TRIM_RSVD_LSB 12
`define CTRL_BG_CAL_BIT 0
`define CTRL_BG_OFS_BIT 1
`define CTRL_FG_OFS_BIT 2
`define STAT_FOREGROUND_CALIBRATION_COMPLETE_BIT 0
`define STAT_STOPPED_BIT 1
`define STAT_FG_RUNNING_BIT 2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RESET_CAL_CONTROL 3'h0
`define RESET_TRIM_FACTORY 16'h0800

// ----------------------------------------------------------------------------
// AXI response codes
// ----------------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: rtl/offset_trim_pkg.sv
// Types shared by the offset trim bank modules.
package offset_trim_pkg;

  typedef logic [15:0] trim_word_type;

  typedef enum {
    sel_trim,
    sel_ctrl,
    sel_stat,
    sel_none
  } reg_sel_type;

  typedef struct packed {
    logic aw_ready;
    logic [11:0] awaddr;
    logic w_ready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_ready;
    logic rd_pend;
    logic [11:0] araddr;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] cal_ctrl;
  } bus_state_type;

  typedef struct packed {
    trim_word_type [2:0] words;
    trim_word_type rdata;
  } store_state_type;

endpackage

// file: rtl/trim_store_if.sv
// Carrier between the bus slave and the trim word store.
`timescale 1ns/100ps
interface trim_store_if;
  import offset_trim_pkg::*;
  logic we;
  logic [1:0] waddr;
  logic [15:0] wdata;
  logic [1:0] wstrb;
  logic re;
  logic [1:0] raddr;
  trim_word_type rdata;
  trim_word_type [2:0] words;

  modport store (input we, waddr, wdata, wstrb, re, raddr, output rdata, words);
  modport user (output we, waddr, wdata, wstrb, re, raddr, input rdata, words);
endinterface

// file: rtl/trim_store.sv
// Three 16-bit trim words with byte write and registered read data.
`timescale 1ns/100ps
`include "offset_trim_consts.svh"
module trim_store
  import offset_trim_pkg::*;
#(
  parameter trim_word_type FACTORY_TRIM_0 = `RESET_TRIM_FACTORY,
  parameter trim_word_type FACTORY_TRIM_1 = `RESET_TRIM_FACTORY,
  parameter trim_word_type FACTORY_TRIM_2 = `RESET_TRIM_FACTORY
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Store port
  trim_store_if.store port
);

  store_state_type state;
  store_state_type next_state;

  always_comb begin
    next_state = state;
    if (port.we && port.waddr <= 2'd2) begin
      if (port.wstrb[0]) begin
        next_state.words[port.waddr][7:0] = port.wdata[7:0]; // R5
      end
      if (port.wstrb[1]) begin
        next_state.words[port.waddr][15:8] = port.wdata[15:8]; // R5
      end
    end
    if (port.re) begin
      next_state.rdata = (port.raddr <= 2'd2) ? state.words[port.raddr] : 16'h0000;
    end
  end

  // Factory values are parameters so that every reset returns the trimmed setting.
  // The reserved nibble always resets to zero, whatever the factory word holds.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state.words[0] <= {4'h0, FACTORY_TRIM_0[`TRIM_VALUE_MSB:0]}; // R5
      state.words[1] <= {4'h0, FACTORY_TRIM_1[`TRIM_VALUE_MSB:0]}; // R5
      state.words[2] <= {4'h0, FACTORY_TRIM_2[`TRIM_VALUE_MSB:0]}; // R5
      state.rdata <= 16'h0000;
    end else begin
      state <= next_state;
    end
  end

  assign port.rdata = state.rdata;
  assign port.words = state.words;

endmodule // trim_store

// file: verification/offset_trim_regs_chk.sv
// Port-level assertions for the offset trim register bank.
`timescale 1ns/100ps
module offset_trim_regs_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Applied offsets
  input wire logic [11:0] offset_trim_core0_input_b,
  input wire logic [11:0] offset_trim_core1_input_a,
  input wire logic [11:0] offset_trim_core1_input_b
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
      |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##1 s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  // Offsets may only move together with the response of the write that set them.
  property p_trim0;
    !$stable(offset_trim_core0_input_b) |-> $rose(s_axi_bvalid);
  endproperty
  a_trim0: assert property (p_trim0) else $error("core0 b offset moved");
  property p_trim1;
    !$stable(offset_trim_core1_input_a) |-> $rose(s_axi_bvalid);
  endproperty
  a_trim1: assert property (p_trim1) else $error("core1 a offset moved");
  property p_trim2;
    !$stable(offset_trim_core1_input_b) |-> $rose(s_axi_bvalid);
  endproperty
  a_trim2: assert property (p_trim2) else $error("core1 b offset moved");
  property p_no_sign;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_no_sign: assert property (p_no_sign) else $error("read data upper half set");
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("read data dropped");
  property p_b_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("write response dropped");
  c_r_stall: cover property (s_axi_rvalid && !s_axi_rready);
  c_b_stall: cover property (s_axi_bvalid && !s_axi_bready);
  c_trim: cover property (!$stable(offset_trim_core1_input_b));
endmodule // offset_trim_regs_chk

// file: verification/offset_trim_regs_tb.sv
// Self-checking bench for the offset trim register bank.
`timescale 1ns/100ps
`include "offset_trim_consts.svh"
module offset_trim_regs_tb;
  import offset_trim_pkg::*;
  localparam trim_word_type FACT [3] = '{16'h0123, 16'h0fed, 16'h0a5a};
  localparam trim_word_type WVAL [3] = '{16'h0fff, 16'h0000, 16'h0801};
  localparam logic [11:0] TADDR [3] = '{{`IDX_TRIM_CORE0_INPUT_B, 2'b00},
    {`IDX_TRIM_CORE1_INPUT_A, 2'b00}, {`IDX_TRIM_CORE1_INPUT_B, 2'b00}};
  localparam logic [11:0] CTRL = {`IDX_CAL_CONTROL, 2'b00};
  localparam logic [11:0] STAT = {`IDX_CAL_STATUS, 2'b00};
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [2:0] cal_in = 3'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [2:0] cal_en;
  logic [11:0] trim_out [3];
  trim_word_type mirror [3];
  int error_cnt = 0, n_tests = 0;
  bit stall = 0;

  offset_trim_regs #(.FACTORY_TRIM_0(FACT[0]), .FACTORY_TRIM_1(FACT[1]),
    .FACTORY_TRIM_2(FACT[2])) dut (.ref_clk, .nrst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .foreground_calibration_running(cal_in[2]),
    .foreground_calibration_complete(cal_in[0]), .calibration_stopped_flag(cal_in[1]),
    .background_calibration_enable(cal_en[0]), .background_offset_calibration_enable(cal_en[1]),
    .foreground_offset_calibration_enable(cal_en[2]), .offset_trim_core0_input_b(trim_out[0]),
    .offset_trim_core1_input_a(trim_out[1]), .offset_trim_core1_input_b(trim_out[2]));

  always #12.5 ref_clk = ~ref_clk;

  // ---------------------------------------------------------------------------
  // Bus tasks and comparisons
  // ---------------------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // For a read, d is the expected data. Entered only right after a rising edge.
  task automatic xfer(input bit wr, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [1:0] er);
    int n;
    bit got;
    n = 0;
    got = 0;
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !stall;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !stall;
    end
    while (!got) begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (wr ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready) begin
        got = 1;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        chk("resp", {30'h0, er}, {30'h0, wr ? s_axi_bresp : s_axi_rresp});
        if (!wr) chk("rdata", d, s_axi_rdata);
      end else if (s_axi_bvalid || s_axi_rvalid) begin
        s_axi_bready <= wr;
        s_axi_rready <= !wr;
      end
      if (n > 40) begin
        $display("Error bus answer expected within 40 cycles seen none");
        error_cnt++;
        give_verdict();
      end
    end
    @(posedge ref_clk);
  endtask

  task automatic chk_trims();
    for (int i = 0; i < 3; i++) begin
      chk("trim_out", {20'h0, mirror[i][11:0]}, {20'h0, trim_out[i]});
    end
  endtask

  initial begin
    mirror = FACT;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk_trims();
    for (int i = 0; i < 3; i++) xfer(0, TADDR[i], {16'h0, FACT[i]}, 4'h0, `RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      xfer(1, TADDR[i], {16'hdead, WVAL[i]}, 4'hf, `RESP_OKAY);
    end
    mirror = WVAL;
    chk_trims();
    stall = 1;
    for (int i = 0; i < 3; i++) xfer(0, TADDR[i], {16'h0, WVAL[i]}, 4'h0, `RESP_OKAY);
    xfer(1, TADDR[2], 32'h0000_0034, 4'h1, `RESP_OKAY);
    xfer(1, TADDR[2], 32'h0000_0600, 4'h2, `RESP_OKAY);
    stall = 0;
    mirror[2] = 16'h0634;
    xfer(1, 12'h234, 32'h0000_0111, 4'hf, `RESP_SLVERR);
    xfer(0, TADDR[0] + 12'h002, 32'h0, 4'h0, `RESP_SLVERR);
    chk_trims();
    xfer(1, CTRL, 32'h0000_0004, 4'hf, `RESP_OKAY);
    chk("cal_en", 32'h4, {29'h0, cal_en});
    cal_in <= 3'h1;
    xfer(0, STAT, 32'h0000_0001, 4'h0, `RESP_OKAY);
    xfer(0, TADDR[2], 32'h0000_0634, 4'h0, `RESP_OKAY);
    xfer(1, CTRL, 32'h0000_0003, 4'hf, `RESP_OKAY);
    cal_in <= 3'h2;
    xfer(1, STAT, 32'h0000_0007, 4'hf, `RESP_OKAY);
    xfer(0, STAT, 32'h0000_0002, 4'h0, `RESP_OKAY);
    xfer(0, TADDR[0], 32'h0000_0fff, 4'h0, `RESP_OKAY);
    cal_in <= 3'h4;
    xfer(0, STAT, 32'h0000_0004, 4'h0, `RESP_OKAY);
    xfer(0, CTRL, 32'h0000_0003, 4'h0, `RESP_OKAY);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    mirror = FACT;
    chk_trims();
    chk("cal_en", 32'h0, {29'h0, cal_en});
    nrst <= 1'b1;
    @(posedge ref_clk);
    xfer(0, TADDR[1], {16'h0, FACT[1]}, 4'h0, `RESP_OKAY);
    give_verdict();
  end
endmodule // offset_trim_regs_tb

bind offset_trim_regs offset_trim_regs_chk chk (.ref_clk, .nrst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .offset_trim_core0_input_b,
  .offset_trim_core1_input_a, .offset_trim_core1_input_b);
